/* File: shared/pds_pkg.sv */
// Purpose: Shared constants for the port D / port E pin sharing block
// Assumes: One system clock, synchronous active-low reset
// Notes: Bit positions of the shared pins within their ports
package pds_pkg;
    // Port widths and shared pin positions
    localparam int unsigned PDS_PORT_D_WIDTH = 7;
    localparam int unsigned PDS_PORT_E_WIDTH = 2;
    localparam int unsigned PDS_SELECT_PINS = 6;
    localparam int unsigned PDS_D_SERIAL1_TX_BIT = 6;
    localparam int unsigned PDS_E_SERIAL0_TX_BIT = 0;
    localparam int unsigned PDS_E_SERIAL0_RX_BIT = 1;
    // Reset values: chip selects start as general purpose, serial pins start as peripheral
    localparam logic [6:0] PDS_PORT_D_PER_RESET = 7'h40;
    localparam logic [1:0] PDS_PORT_E_PER_RESET = 2'h3;
    localparam logic [6:0] PDS_PORT_D_DIR_RESET = 7'h00;
    localparam logic [1:0] PDS_PORT_E_DIR_RESET = 2'h0;
    localparam logic [6:0] PDS_PORT_D_OUT_RESET = 7'h00;
    localparam logic [1:0] PDS_PORT_E_OUT_RESET = 2'h0;
    // Pull-up registers reset with all bits set
    localparam logic [6:0] PDS_PORT_D_PUR_RESET = 7'h7f;
    localparam logic [1:0] PDS_PORT_E_PUR_RESET = 2'h3;
    // Block phase states: held in reset or running
    typedef enum logic [0:0] {
        PDS_IN_RESET,
        PDS_RUNNING
    } pds_phase_type;
endpackage : pds_pkg

/* File: src/pds_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input is asynchronous to i_clock
// Notes: First stage feeds only the second stage
module pds_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Refuse an empty bus
    if (WIDTH < 1) begin : g_bad_width
        $error("pds_sync: WIDTH must be at least 1");
    end

    // Next values of both stages
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // Register the two stages
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule : pds_sync

/* File: src/pds_pin_share.sv */
// Purpose: Pin sharing for port D pins 0..6 and port E pins 0..1
// Assumes: Control bits arrive from same-clock logic; pin levels are asynchronous
// Notes: Pins appear as input, output and output enable; pull-up enables are outputs
//        Every output is registered, so a control change shows one edge later
//        Pin levels reach the read-back outputs on the third edge after they settle
//        Reset floats every pin; the caller applies the peripheral enable defaults
//        Port D pin 6 pull-up is set-to-disable, so the all-ones reset leaves it off
//        Idle selects float unless the idle drive control keeps them driven
//        The serial zero receive pin is never driven while the serial unit owns it
//        Receive reads high whenever its pin is not handed to the serial unit
//        Port E pin 0 and port D pin 6 drive their transmit lines whenever owned
module pds_pin_share
    import pds_pkg::*;
#(
    parameter int unsigned D_WIDTH = PDS_PORT_D_WIDTH,
    parameter int unsigned E_WIDTH = PDS_PORT_E_WIDTH
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Port D software controls
    input wire logic [6:0] i_port_d_peripheral_enable_reg,
    input wire logic [6:0] i_port_d_direction,
    input wire logic [6:0] i_port_d_data_out,
    input wire logic i_port_d_pullup_write,
    input wire logic [6:0] i_port_d_pullup_wdata,
    // Port E software controls
    input wire logic [1:0] i_port_e_peripheral_enable_reg,
    input wire logic [1:0] i_port_e_direction,
    input wire logic [1:0] i_port_e_data_out,
    input wire logic i_port_e_pullup_write,
    input wire logic [1:0] i_port_e_pullup_wdata,
    // External memory interface
    input wire logic [5:0] i_ext_select,
    input wire logic i_ext_bus_active,
    input wire logic i_idle_bus_drive_control,
    // Serial units
    input wire logic i_serial0_tx_line,
    input wire logic i_serial1_tx_line,
    output logic o_serial0_rx_line,
    // Port D pins
    input wire logic [6:0] i_port_d_pin,
    output logic [6:0] o_port_d_pin,
    output logic [6:0] o_port_d_pin_oe,
    output logic [6:0] o_port_d_pullup_en,
    output logic [6:0] o_port_d_data_in,
    // Port E pins
    input wire logic [1:0] i_port_e_pin,
    output logic [1:0] o_port_e_pin,
    output logic [1:0] o_port_e_pin_oe,
    output logic [1:0] o_port_e_pullup_en,
    output logic [1:0] o_port_e_data_in,
    // Register read-back
    output logic [6:0] o_port_d_pullup_reg,
    output logic [1:0] o_port_e_pullup_reg
);
    // Refuse widths that the fixed pin map cannot serve
    if (D_WIDTH != PDS_PORT_D_WIDTH) begin : g_bad_d_width
        $error("pds_pin_share: D_WIDTH must be 7");
    end
    if (E_WIDTH != PDS_PORT_E_WIDTH) begin : g_bad_e_width
        $error("pds_pin_share: E_WIDTH must be 2");
    end

    // Pull-up register state
    logic [6:0] port_d_pullup_reg_q;
    logic [6:0] port_d_pullup_reg_d;
    logic [1:0] port_e_pullup_reg_q;
    logic [1:0] port_e_pullup_reg_d;

    // Port D pin drive state
    logic [6:0] d_out_q;
    logic [6:0] d_out_d;
    logic [6:0] d_oe_q;
    logic [6:0] d_oe_d;

    // Port E pin drive state
    logic [1:0] e_out_q;
    logic [1:0] e_out_d;
    logic [1:0] e_oe_q;
    logic [1:0] e_oe_d;

    // Pull-up enable state
    logic [6:0] d_pu_q;
    logic [6:0] d_pu_d;
    logic [1:0] e_pu_q;
    logic [1:0] e_pu_d;

    // Input sampling state
    logic [6:0] d_in_q;
    logic [6:0] d_in_d;
    logic [1:0] e_in_q;
    logic [1:0] e_in_d;
    logic rx_q;
    logic rx_d;

    // Synchronised pin levels
    logic [6:0] d_pin_sync;
    logic [1:0] e_pin_sync;

    // Drive enable for a general purpose pin: output only when direction bit is set
    // A cleared direction bit leaves the pin as an input for the far end to drive
    function automatic logic gp_drive(input logic dir);
        return dir;
    endfunction : gp_drive

    // Select lines drive while the bus is active, or when idle if drive bit set
    // Holding them driven on an idle bus avoids floating selects without pull-ups
    function automatic logic select_drive(input logic active, input logic keep);
        return active | keep;
    endfunction : select_drive

    // Pull-up enable per port D pin; pin 6 inverts because its bit is set-to-disable
    function automatic logic [6:0] d_pull_enable(input logic [6:0] pull_bits);
        logic [6:0] enable;
        enable = pull_bits;
        enable[PDS_D_SERIAL1_TX_BIT] = ~pull_bits[PDS_D_SERIAL1_TX_BIT];
        return enable;
    endfunction : d_pull_enable

    // Bring pin levels into the clock domain
    // Pins are asynchronous, so nothing reads them before the second stage
    pds_sync #(
        .WIDTH(9)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_async({i_port_e_pin, i_port_d_pin}),
        .o_sync({e_pin_sync, d_pin_sync})
    );

    // Pull-up register writes; a strobe loads the whole register
    // Software writes every bit at once, so there is no per-bit mask
    always_comb begin
        port_d_pullup_reg_d = port_d_pullup_reg_q;
        port_e_pullup_reg_d = port_e_pullup_reg_q;
        if (i_port_d_pullup_write) begin
            port_d_pullup_reg_d = i_port_d_pullup_wdata;
        end
        if (i_port_e_pullup_write) begin
            port_e_pullup_reg_d = i_port_e_pullup_wdata;
        end
    end

    // Register pull-up contents; reset turns every pull-up bit on
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            port_d_pullup_reg_q <= PDS_PORT_D_PUR_RESET;
            port_e_pullup_reg_q <= PDS_PORT_E_PUR_RESET;
        end else begin
            port_d_pullup_reg_q <= port_d_pullup_reg_d;
            port_e_pullup_reg_q <= port_e_pullup_reg_d;
        end
    end

    // Port D pin drive: ownership, direction and select decode
    always_comb begin
        d_out_d = '0;
        d_oe_d = '0;
        // Port D pins 0..5: general purpose or external selects
        // Select bit 0 is external select line 2, bit 5 is line 7
        for (int i = 0; i < PDS_SELECT_PINS; i++) begin
            if (i_port_d_peripheral_enable_reg[i]) begin
                d_out_d[i] = i_ext_select[i];
                d_oe_d[i] = select_drive(i_ext_bus_active, i_idle_bus_drive_control);
            end else begin
                d_out_d[i] = i_port_d_data_out[i];
                d_oe_d[i] = gp_drive(i_port_d_direction[i]);
            end
        end
        // Port D pin 6: serial one transmit or general purpose
        if (i_port_d_peripheral_enable_reg[PDS_D_SERIAL1_TX_BIT]) begin
            d_out_d[PDS_D_SERIAL1_TX_BIT] = i_serial1_tx_line;
            d_oe_d[PDS_D_SERIAL1_TX_BIT] = 1'b1;
        end else begin
            d_out_d[PDS_D_SERIAL1_TX_BIT] = i_port_d_data_out[PDS_D_SERIAL1_TX_BIT];
            d_oe_d[PDS_D_SERIAL1_TX_BIT] = gp_drive(i_port_d_direction[PDS_D_SERIAL1_TX_BIT]);
        end
    end

    // Port E pin drive: serial zero lines or general purpose
    always_comb begin
        e_out_d = '0;
        e_oe_d = '0;
        // Port E pin 0: serial zero transmit or general purpose
        if (i_port_e_peripheral_enable_reg[PDS_E_SERIAL0_TX_BIT]) begin
            e_out_d[PDS_E_SERIAL0_TX_BIT] = i_serial0_tx_line;
            e_oe_d[PDS_E_SERIAL0_TX_BIT] = 1'b1;
        end else begin
            e_out_d[PDS_E_SERIAL0_TX_BIT] = i_port_e_data_out[PDS_E_SERIAL0_TX_BIT];
            e_oe_d[PDS_E_SERIAL0_TX_BIT] = gp_drive(i_port_e_direction[PDS_E_SERIAL0_TX_BIT]);
        end
        // Port E pin 1: serial zero receive (input only) or general purpose
        // Never driven while owned, so the far transmitter cannot fight the block
        if (i_port_e_peripheral_enable_reg[PDS_E_SERIAL0_RX_BIT]) begin
            e_out_d[PDS_E_SERIAL0_RX_BIT] = 1'b0;
            e_oe_d[PDS_E_SERIAL0_RX_BIT] = 1'b0;
        end else begin
            e_out_d[PDS_E_SERIAL0_RX_BIT] = i_port_e_data_out[PDS_E_SERIAL0_RX_BIT];
            e_oe_d[PDS_E_SERIAL0_RX_BIT] = gp_drive(i_port_e_direction[PDS_E_SERIAL0_RX_BIT]);
        end
    end

    // Register port D pin drive; all pins float in reset
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            d_out_q <= PDS_PORT_D_OUT_RESET;
            d_oe_q <= PDS_PORT_D_DIR_RESET;
        end else begin
            d_out_q <= d_out_d;
            d_oe_q <= d_oe_d;
        end
    end

    // Register port E pin drive; both pins float in reset
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            e_out_q <= PDS_PORT_E_OUT_RESET;
            e_oe_q <= PDS_PORT_E_DIR_RESET;
        end else begin
            e_out_q <= e_out_d;
            e_oe_q <= e_oe_d;
        end
    end

    // Pull-up enables track the value the register takes at this edge
    always_comb begin
        d_pu_d = d_pull_enable(port_d_pullup_reg_d);
        e_pu_d[PDS_E_SERIAL0_TX_BIT] = port_e_pullup_reg_d[PDS_E_SERIAL0_TX_BIT];
        e_pu_d[PDS_E_SERIAL0_RX_BIT] = port_e_pullup_reg_d[PDS_E_SERIAL0_RX_BIT];
    end

    // Register pull-up enables; the all-ones reset leaves port D pin 6 off
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            d_pu_q <= d_pull_enable(PDS_PORT_D_PUR_RESET);
            e_pu_q <= PDS_PORT_E_PUR_RESET;
        end else begin
            d_pu_q <= d_pu_d;
            e_pu_q <= e_pu_d;
        end
    end

    // Port D read-back: synchronised pin levels
    always_comb begin
        d_in_d = d_pin_sync;
    end

    // Register port D read-back
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            d_in_q <= '0;
        end else begin
            d_in_q <= d_in_d;
        end
    end

    // Port E read-back and serial zero receive; receive idles high unless handed over
    always_comb begin
        e_in_d = e_pin_sync;
        rx_d = i_port_e_peripheral_enable_reg[PDS_E_SERIAL0_RX_BIT]
               ? e_pin_sync[PDS_E_SERIAL0_RX_BIT] : 1'b1;
    end

    // Register port E read-back; the receive line rests high in reset
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            e_in_q <= '0;
            rx_q <= 1'b1;
        end else begin
            e_in_q <= e_in_d;
            rx_q <= rx_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_port_d_pin = d_out_q;
    assign o_port_d_pin_oe = d_oe_q;
    assign o_port_d_pullup_en = d_pu_q;
    assign o_port_d_data_in = d_in_q;
    assign o_port_e_pin = e_out_q;
    assign o_port_e_pin_oe = e_oe_q;
    assign o_port_e_pullup_en = e_pu_q;
    assign o_port_e_data_in = e_in_q;
    assign o_serial0_rx_line = rx_q;
    assign o_port_d_pullup_reg = port_d_pullup_reg_q;
    assign o_port_e_pullup_reg = port_e_pullup_reg_q;
endmodule : pds_pin_share

/* File: tb/pds_pin_share_props.sv */
// Purpose: Port-level assertions for the pin sharing block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the top module
module pds_pin_share_chk (
    // Clock, reset and controls
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [6:0] i_port_d_peripheral_enable_reg,
    input wire logic [6:0] i_port_d_direction,
    input wire logic [1:0] i_port_e_peripheral_enable_reg,
    input wire logic [5:0] i_ext_select,
    input wire logic i_ext_bus_active,
    input wire logic i_idle_bus_drive_control,
    input wire logic i_serial0_tx_line,
    input wire logic i_serial1_tx_line,
    // Observed outputs
    input wire logic [6:0] o_port_d_pin,
    input wire logic [6:0] o_port_d_pin_oe,
    input wire logic [6:0] o_port_d_pullup_en,
    input wire logic [1:0] o_port_e_pin,
    input wire logic [1:0] o_port_e_pin_oe,
    input wire logic [1:0] o_port_e_pullup_en,
    input wire logic [6:0] o_port_d_pullup_reg,
    input wire logic [1:0] o_port_e_pullup_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    // Which select pins are general purpose, and which must drive or float
    logic [5:0] gp;
    logic [5:0] gp_dir;
    logic [5:0] sel_on;
    logic [5:0] sel_off;
    assign gp = ~i_port_d_peripheral_enable_reg[5:0];
    assign gp_dir = gp & i_port_d_direction[5:0];
    assign sel_on = ~gp & {6{i_ext_bus_active | i_idle_bus_drive_control}};
    assign sel_off = ~gp & ~{6{i_ext_bus_active | i_idle_bus_drive_control}};
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // Reset behaviour is checked with reset itself as the cause
    a_reset_float: assert property (disable iff (1'b0) !i_nrst |=>
        o_port_d_pin_oe == 7'h00 && o_port_e_pin_oe == 2'h0) else $error("pin driven in reset");
    a_pull_reset: assert property (disable iff (1'b0) !i_nrst |=>
        o_port_d_pullup_reg == 7'h7f && o_port_e_pullup_reg == 2'h3) else $error("pull-up reset");
    // Ownership, direction and routing one cycle after the cause; pull-up map in the same cycle
    a_gp_dir: assert property (1 |=> (o_port_d_pin_oe[5:0] & $past(gp)) == $past(gp_dir))
        else $error("direction not followed");
    a_sel_idle: assert property (1 |=> (o_port_d_pin_oe[5:0] & $past(sel_off)) == 6'h00)
        else $error("select driven on idle bus");
    a_sel_route: assert property (1 |=> (o_port_d_pin_oe[5:0] & $past(sel_on)) == $past(sel_on)
        && ((o_port_d_pin[5:0] ^ $past(i_ext_select)) & $past(sel_on)) == 6'h00)
        else $error("select not routed");
    a_tx0_route: assert property (i_port_e_peripheral_enable_reg[0] |=> o_port_e_pin_oe[0]
        && o_port_e_pin[0] == $past(i_serial0_tx_line)) else $error("serial zero tx");
    a_tx1_route: assert property (i_port_d_peripheral_enable_reg[6] |=> o_port_d_pin_oe[6]
        && o_port_d_pin[6] == $past(i_serial1_tx_line)) else $error("serial one tx");
    a_rx_input: assert property (i_port_e_peripheral_enable_reg[1] |=> !o_port_e_pin_oe[1])
        else $error("receive pin driven");
    a_pull_map: assert property (o_port_e_pullup_en == o_port_e_pullup_reg
        && o_port_d_pullup_en == {~o_port_d_pullup_reg[6], o_port_d_pullup_reg[5:0]})
        else $error("pull-up map");
    // Main scenarios reached
    c_sel_on: cover property (sel_on != 6'h00);
    c_tx_both: cover property (i_port_d_peripheral_enable_reg[6] && i_port_e_peripheral_enable_reg[0]);
    c_rx_on: cover property (i_port_e_peripheral_enable_reg[1]);
endmodule : pds_pin_share_chk

bind pds_pin_share pds_pin_share_chk pds_pin_share_chk_i (.*);

/* File: tb/pds_far_end.sv */
// Purpose: Far-side pin model: memory devices, line transceivers, pull-ups
// Assumes: Pin enable is high while the block drives
// Notes: A floating pin without pull-up shows the inverse of its last level
module pds_far_end #(
    parameter int W = 2
) (
    input wire logic i_clock,
    input wire logic [W-1:0] i_drv,
    input wire logic [W-1:0] i_drv_oe,
    input wire logic [W-1:0] i_pu,
    input wire logic [W-1:0] i_ext,
    input wire logic [W-1:0] i_ext_oe,
    output logic [W-1:0] o_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [W-1:0] last_q = '0;
    // Block drive wins, then the far device, then pull-up or a changing level
    always_comb begin
        o_level = (i_drv & i_drv_oe) | (i_ext & i_ext_oe & ~i_drv_oe)
            | (~i_drv_oe & ~i_ext_oe & (i_pu | ~last_q));
    end
    // Last settled level of each pin
    always_ff @(posedge i_clock) begin
        last_q <= o_level;
    end
endmodule : pds_far_end

/* File: tb/pds_pin_share_test.sv */
// Purpose: Self-checking bench for the pin sharing block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Random control mix plus reset and receive corners
module pds_pin_share_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic [6:0] i_port_d_peripheral_enable_reg, i_port_d_direction, i_port_d_data_out;
    logic [6:0] i_port_d_pullup_wdata, i_port_d_pin, o_port_d_pin, o_port_d_pin_oe;
    logic [6:0] o_port_d_pullup_en, o_port_d_data_in, o_port_d_pullup_reg, ext_d, ext_oe_d, pr_d;
    logic [1:0] i_port_e_peripheral_enable_reg, i_port_e_direction, i_port_e_data_out;
    logic [1:0] i_port_e_pullup_wdata, i_port_e_pin, o_port_e_pin, o_port_e_pin_oe;
    logic [1:0] o_port_e_pullup_en, o_port_e_data_in, o_port_e_pullup_reg, ext_e, ext_oe_e, pr_e;
    logic [5:0] i_ext_select;
    logic i_port_d_pullup_write, i_port_e_pullup_write, i_ext_bus_active;
    logic i_idle_bus_drive_control, i_serial0_tx_line, i_serial1_tx_line, o_serial0_rx_line;
    int seed;
    int mismatches = 0;
    int n_checks = 0;
    pds_pin_share pds_pin_share_i (.*);
    pds_far_end #(.W(7)) pds_far_end_d_i (.i_clock, .i_drv(o_port_d_pin), .i_drv_oe(o_port_d_pin_oe),
        .i_pu(o_port_d_pullup_en), .i_ext(ext_d), .i_ext_oe(ext_oe_d), .o_level(i_port_d_pin));
    pds_far_end #(.W(2)) pds_far_end_e_i (.i_clock, .i_drv(o_port_e_pin), .i_drv_oe(o_port_e_pin_oe),
        .i_pu(o_port_e_pullup_en), .i_ext(ext_e), .i_ext_oe(ext_oe_e), .o_level(i_port_e_pin));
    // 100 MHz clock
    always #5 i_clock = ~i_clock;
    // Compare and report
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // All inputs except reset from the seeded generator
    task automatic drive_random();
        logic [31:0] r1, r2, r3;
        r1 = $random(seed);
        r2 = $random(seed);
        r3 = $random(seed);
        {i_port_d_peripheral_enable_reg, i_port_d_direction, i_port_d_data_out} = r1[20:0];
        {i_port_e_peripheral_enable_reg, i_port_e_direction, i_port_e_data_out,
            i_port_e_pullup_wdata, i_port_d_pullup_wdata} = r2[14:0];
        {i_ext_select, i_ext_bus_active, i_idle_bus_drive_control, i_serial0_tx_line,
            i_serial1_tx_line} = r2[24:15];
        i_port_d_pullup_write = r3[1:0] == 2'h0;
        i_port_e_pullup_write = r3[3:2] == 2'h0;
        {ext_d, ext_oe_d, ext_e, ext_oe_e} = r3[21:4];
    endtask : drive_random
    // One edge, then outputs against the inputs that edge sampled
    task automatic step();
        logic [6:0] eo, pd;
        logic [1:0] ee, pe;
        @(posedge i_clock);
        #1;
        eo = (~i_port_d_peripheral_enable_reg & i_port_d_direction) | (i_port_d_peripheral_enable_reg
            & {1'b1, {6{i_ext_bus_active | i_idle_bus_drive_control}}});
        pd = (i_port_d_peripheral_enable_reg & {i_serial1_tx_line, i_ext_select})
            | (~i_port_d_peripheral_enable_reg & i_port_d_data_out);
        ee = (~i_port_e_peripheral_enable_reg & i_port_e_direction)
            | (i_port_e_peripheral_enable_reg & 2'h1);
        pe = (i_port_e_peripheral_enable_reg & {1'b0, i_serial0_tx_line})
            | (~i_port_e_peripheral_enable_reg & i_port_e_data_out);
        if (!i_nrst) begin
            {pr_d, pr_e, eo, ee} = {7'h7f, 2'h3, 7'h00, 2'h0};
        end else begin
            if (i_port_d_pullup_write) pr_d = i_port_d_pullup_wdata;
            if (i_port_e_pullup_write) pr_e = i_port_e_pullup_wdata;
        end
        cmp({o_port_e_pin_oe, o_port_d_pin_oe}, {ee, eo});
        cmp({o_port_e_pin & ee, o_port_d_pin & eo}, {pe & ee, pd & eo});
        cmp({o_port_e_pullup_reg, o_port_d_pullup_reg}, {pr_e, pr_d});
        cmp({o_port_e_pullup_en, o_port_d_pullup_en}, {pr_e, ~pr_d[6], pr_d[5:0]});
    endtask : step
    // Reset with random inputs, then the software reset ownership
    task automatic reset_check();
        drive_random();
        i_nrst = 1'b0;
        repeat (2) step();
        i_nrst = 1'b1;
        {i_port_d_peripheral_enable_reg, i_port_d_direction} = {7'h40, 7'h00};
        {i_port_e_peripheral_enable_reg, i_port_e_direction} = {2'h3, 2'h0};
        {i_port_d_pullup_write, i_port_e_pullup_write} = 2'b00;
        step();
        $display("reset defaults done");
    endtask : reset_check
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        seed = 32'h09f1;
        reset_check();
        for (int k = 0; k < 400; k++) begin
            drive_random();
            step();
        end
        $display("random mix done");
        for (int v = 0; v < 3; v++) begin
            {i_port_e_peripheral_enable_reg, i_port_e_direction} = (v < 2) ? 4'hc : 4'h4;
            {i_port_d_peripheral_enable_reg, i_port_d_direction} = 14'h0000;
            {ext_e, ext_oe_e, ext_oe_d, ext_d} = {v[0], 3'h2, 7'h7f, {7{v[0]}}};
            repeat (4) step();
            cmp(o_serial0_rx_line, (v < 2) ? v[0] : 1'b1);
            cmp({o_port_e_data_in[1], o_port_d_data_in}, {v[0], ext_d});
        end
        $display("receive path done");
        reset_check();
        close_out();
    end
endmodule : pds_pin_share_test
